// file: hdl/rag_top.sv
// Purpose: APB register block around the relative address adder
// Assumes: one 40 MHz clock, APB master keeps the request until pready
// Notes:   every APB transfer takes one access cycle
//
// How it works
// RL1 - native relative jump wraps in 16 bits, upper program counter half zero
// RL2 - extended relative jump wraps in 32 bits, carry reaches upper half
// RL3 - jump displacement sign-extended to 32 bits extended, 16 bits native
// RL4 - jump base is the address after the whole instruction
// RL5 - stack operand address is stack pointer plus signed 8-bit displacement
// RL6 - byte extension widens stack offset to 16 bits, word extension to 24
// RL7 - native stack address wraps in 16 bits, extended one in 32 bits
// RL8 - native 8-bit stack displacement is sign-extended to 16 bits
// RL9 - stack transfers are 16 bits, or 32 with long word setting
// RL10 - I/O accesses are 8 or 16 bits, byte is the basic element
// RL11 - block operations handle strings up to 65536 bytes
// RL12 - BCD digits are four bits, two packed per byte
// RL13 - indexed addressing takes 8, 16 or 24 bit signed displacement
// RL14 - single bits of a byte can be tested, set and cleared
// RL15 - multi-byte operands are little-endian, low byte at lowest address
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module rag_top
  import rag_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // memory or I/O access request
  output logic [31:0]      memAddr,
  output logic [31:0]      memWdata,
  output logic [3:0]       memByteEn,
  output logic             memIsIo,
  output logic             calcDone
);

  rag_calc_if calc ();

  rag_addr_unit u_unit (
    .clk    (clk),
    .arst_n (arst_n),
    .calc   (calc)
  );

  logic [CTRL_BITS-1:0]  ctrl_ff,   nxt_ctrl;
  logic [31:0]           pc_ff,     nxt_pc;
  logic [31:0]           sp_ff,     nxt_sp;
  logic [31:0]           index_ff,  nxt_index;
  logic [23:0]           disp_ff,   nxt_disp;
  logic [31:0]           data_ff,   nxt_data;
  logic [BITOP_BITS-1:0] bitop_ff,  nxt_bitop;
  logic [7:0]            bcd_ff,    nxt_bcd;
  logic [15:0]           blk_ff,    nxt_blk;
  logic [31:0]           result_ff, nxt_result;
  logic                  done_ff,   nxt_done;
  logic                  start_ff,  nxt_start;
  rag_state_t            state_ff,  nxt_state;
  logic [31:0]           prdata_ff, nxt_prdata;
  logic                  pready_ff, nxt_pready;
  logic                  pslverr_ff, nxt_pslverr;
  logic [31:0]           memAddr_ff, nxt_memAddr;
  logic [31:0]           memWdata_ff, nxt_memWdata;
  logic [3:0]            memByteEn_ff, nxt_memByteEn;
  logic                  memIsIo_ff, nxt_memIsIo;

  logic                  setupPh;
  logic                  wrEn;
  logic                  mapped;
  logic [7:0]            bitResult;
  logic                  bitTested;
  logic                  bcdOk;
  logic [16:0]           blkBytes;
  rag_op_t               opSel;

  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      REG_CTRL, REG_PC, REG_SP, REG_INDEX, REG_DISP, REG_CMD, REG_RESULT,
      REG_STATUS, REG_DATA, REG_BITOP, REG_BCD, REG_BLKLEN: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : addr_mapped

  // bus decode and derived views of the registers
  always_comb begin
    setupPh   = psel && !penable;
    wrEn      = psel && penable && pready_ff && pwrite;
    mapped    = addr_mapped(paddr);
    opSel     = rag_op_t'(ctrl_ff[CTRL_OP_LSB +: 2]);
    bitTested = bitop_ff[bitop_ff[BITOP_NUM_LSB +: 3]]; // [RL14]
    bitResult = bitop_ff[7:0];
    case (rag_bitop_t'(bitop_ff[BITOP_OP_LSB +: 2]))
      RAG_BIT_SET: bitResult[bitop_ff[BITOP_NUM_LSB +: 3]] = 1'b1; // [RL14]
      RAG_BIT_CLR: bitResult[bitop_ff[BITOP_NUM_LSB +: 3]] = 1'b0; // [RL14]
      default:     bitResult = bitop_ff[7:0];
    endcase
    // two decimal digits, low digit in the low nibble
    bcdOk    = (bcd_ff[3:0] <= 4'h9) && (bcd_ff[7:4] <= 4'h9); // [RL12]
    // a zero count stands for the full 64K string
    blkBytes = (blk_ff == 16'h0000) ? BLK_MAX : {1'b0, blk_ff}; // [RL11]
  end

  // register file, apb answer and sequencing
  always_comb begin
    nxt_ctrl      = ctrl_ff;
    nxt_pc        = pc_ff;
    nxt_sp        = sp_ff;
    nxt_index     = index_ff;
    nxt_disp      = disp_ff;
    nxt_data      = data_ff;
    nxt_bitop     = bitop_ff;
    nxt_bcd       = bcd_ff;
    nxt_blk       = blk_ff;
    nxt_result    = result_ff;
    nxt_done      = done_ff;
    nxt_start     = 1'b0;
    nxt_state     = state_ff;
    nxt_memAddr   = memAddr_ff;
    nxt_memWdata  = memWdata_ff;
    nxt_memByteEn = memByteEn_ff;
    nxt_memIsIo   = memIsIo_ff;
    // answer one cycle after setup, so every access phase is one cycle
    nxt_pready    = setupPh;
    nxt_pslverr   = setupPh && !mapped;
    nxt_prdata    = WORD_RST;
    if (setupPh && !pwrite) begin
      case (paddr)
        REG_CTRL:   nxt_prdata = 32'(ctrl_ff);
        REG_PC:     nxt_prdata = pc_ff;
        REG_SP:     nxt_prdata = sp_ff;
        REG_INDEX:  nxt_prdata = index_ff;
        REG_DISP:   nxt_prdata = 32'(disp_ff);
        REG_RESULT: nxt_prdata = result_ff;
        REG_STATUS: nxt_prdata = {24'h00_0000, memByteEn_ff, 2'b00, (state_ff == RAG_ST_CALC), done_ff};
        REG_DATA:   nxt_prdata = data_ff;
        REG_BITOP:  nxt_prdata = {15'h0000, bitTested, 8'h00, bitResult};
        REG_BCD:    nxt_prdata = {23'h00_0000, bcdOk, bcd_ff};
        REG_BLKLEN: nxt_prdata = 32'(blkBytes);
        default:    nxt_prdata = WORD_RST;
      endcase
    end
    if (wrEn) begin
      case (paddr)
        REG_CTRL:   nxt_ctrl  = pwdata[CTRL_BITS-1:0];
        REG_PC:     nxt_pc    = pwdata;
        REG_SP:     nxt_sp    = pwdata;
        REG_INDEX:  nxt_index = pwdata;
        REG_DISP:   nxt_disp  = pwdata[23:0];
        REG_DATA:   nxt_data  = pwdata;
        REG_BITOP:  nxt_bitop = pwdata[BITOP_BITS-1:0];
        REG_BCD:    nxt_bcd   = pwdata[7:0];
        REG_BLKLEN: nxt_blk   = pwdata[15:0];
        default:    nxt_ctrl  = ctrl_ff;
      endcase
    end
    case (state_ff)
      RAG_ST_IDLE: begin
        // a go while busy is dropped
        if (wrEn && paddr == REG_CMD && pwdata[CMD_GO_BIT]) begin
          nxt_start = 1'b1;
          nxt_done  = 1'b0;
          nxt_state = RAG_ST_CALC;
        end
      end
      RAG_ST_CALC: begin
        if (calc.valid) begin
          nxt_result  = calc.result;
          nxt_done    = 1'b1;
          nxt_state   = RAG_ST_IDLE;
          nxt_memAddr = calc.result;
          // lane i carries the byte for address memAddr+i
          nxt_memWdata = data_ff; // [RL15]
          // a jump makes no access, so it never claims the I/O space
          nxt_memIsIo  = ctrl_ff[CTRL_IO_BIT] && (opSel != RAG_OP_JUMP); // [RL10]
          if (opSel == RAG_OP_JUMP) begin
            nxt_pc        = calc.result; // [RL1] [RL2]
            nxt_memByteEn = 4'h0;
          end else if (ctrl_ff[CTRL_IO_BIT]) begin
            nxt_memByteEn = ctrl_ff[CTRL_IOW_BIT] ? BE_WORD : BE_BYTE; // [RL10]
          end else begin
            nxt_memByteEn = ctrl_ff[CTRL_LW_BIT] ? BE_LONG : BE_WORD; // [RL9]
          end
        end
      end
      default: nxt_state = RAG_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff      <= '0;
      pc_ff        <= WORD_RST;
      sp_ff        <= WORD_RST;
      index_ff     <= WORD_RST;
      disp_ff      <= DISP_RST;
      data_ff      <= WORD_RST;
      bitop_ff     <= '0;
      bcd_ff       <= 8'h00;
      blk_ff       <= 16'h0000;
      result_ff    <= WORD_RST;
      done_ff      <= 1'b0;
      start_ff     <= 1'b0;
      state_ff     <= RAG_ST_IDLE;
      prdata_ff    <= WORD_RST;
      pready_ff    <= 1'b0;
      pslverr_ff   <= 1'b0;
      memAddr_ff   <= WORD_RST;
      memWdata_ff  <= WORD_RST;
      memByteEn_ff <= 4'h0;
      memIsIo_ff   <= 1'b0;
    end else begin
      ctrl_ff      <= nxt_ctrl;
      pc_ff        <= nxt_pc;
      sp_ff        <= nxt_sp;
      index_ff     <= nxt_index;
      disp_ff      <= nxt_disp;
      data_ff      <= nxt_data;
      bitop_ff     <= nxt_bitop;
      bcd_ff       <= nxt_bcd;
      blk_ff       <= nxt_blk;
      result_ff    <= nxt_result;
      done_ff      <= nxt_done;
      start_ff     <= nxt_start;
      state_ff     <= nxt_state;
      prdata_ff    <= nxt_prdata;
      pready_ff    <= nxt_pready;
      pslverr_ff   <= nxt_pslverr;
      memAddr_ff   <= nxt_memAddr;
      memWdata_ff  <= nxt_memWdata;
      memByteEn_ff <= nxt_memByteEn;
      memIsIo_ff   <= nxt_memIsIo;
    end
  end

  // request to the adder, sampled in the start cycle; the go guard drops a go while busy but register writes still land
  assign calc.start    = start_ff;
  assign calc.wide     = ctrl_ff[CTRL_WIDE_BIT];
  assign calc.opSel    = opSel;
  assign calc.dispSize = rag_disp_size(ctrl_ff[CTRL_BEXT_BIT], ctrl_ff[CTRL_WEXT_BIT]); // [RL6] [RL13]
  assign calc.base     = (opSel == RAG_OP_JUMP) ? pc_ff : (opSel == RAG_OP_STACK) ? sp_ff : index_ff;
  assign calc.instLen  = (opSel == RAG_OP_JUMP) ? ctrl_ff[CTRL_ILEN_LSB +: 3] : 3'h0;
  assign calc.disp     = disp_ff;

  assign prdata    = prdata_ff;
  assign pready    = pready_ff;
  assign pslverr   = pslverr_ff;
  assign memAddr   = memAddr_ff;
  assign memWdata  = memWdata_ff;
  assign memByteEn = memByteEn_ff;
  assign memIsIo   = memIsIo_ff;
  assign calcDone  = done_ff;

  a_stack_xfer_width: assert property (@(posedge clk) disable iff (!arst_n) // [RL9]
    state_ff == RAG_ST_CALC && calc.valid && opSel == RAG_OP_STACK && !ctrl_ff[CTRL_IO_BIT]
    |=> memByteEn_ff == (ctrl_ff[CTRL_LW_BIT] ? BE_LONG : BE_WORD) && done_ff)
    else $error("stack transfer width wrong");

  a_io_xfer_width: assert property (@(posedge clk) disable iff (!arst_n) // [RL10]
    done_ff && memIsIo_ff |-> memByteEn_ff == BE_BYTE || memByteEn_ff == BE_WORD)
    else $error("I/O access not 8 or 16 bits");

  a_go_to_done: assert property (@(posedge clk) disable iff (!arst_n) // [RL5]
    start_ff |=> ##1 done_ff && result_ff == memAddr_ff)
    else $error("address not delivered two cycles after go");

  a_bit_set_read: assert property (@(posedge clk) disable iff (!arst_n) // [RL14]
    setupPh && !pwrite && paddr == REG_BITOP && bitop_ff[BITOP_OP_LSB +: 2] == RAG_BIT_SET
    |=> prdata_ff[bitop_ff[BITOP_NUM_LSB +: 3]] == 1'b1 && pready_ff)
    else $error("bit set result wrong");

  c_stack_long: cover property (@(posedge clk) disable iff (!arst_n)
    done_ff && memByteEn_ff == BE_LONG);
  c_bad_addr: cover property (@(posedge clk) disable iff (!arst_n) pready_ff && pslverr_ff);

endmodule : rag_top

// file: hdl/rag_pkg.sv
// Purpose: shared constants and types of the relative address generator
// Assumes: APB register window with 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses on the APB bus
package rag_pkg;

  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_PC     = 8'h04;
  localparam logic [7:0] REG_SP     = 8'h08;
  localparam logic [7:0] REG_INDEX  = 8'h0C;
  localparam logic [7:0] REG_DISP   = 8'h10;
  localparam logic [7:0] REG_CMD    = 8'h14;
  localparam logic [7:0] REG_RESULT = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;
  localparam logic [7:0] REG_DATA   = 8'h20;
  localparam logic [7:0] REG_BITOP  = 8'h24;
  localparam logic [7:0] REG_BCD    = 8'h28;
  localparam logic [7:0] REG_BLKLEN = 8'h2C;

  // control and command field positions
  localparam int CTRL_WIDE_BIT = 0;
  localparam int CTRL_LW_BIT   = 1;
  localparam int CTRL_BEXT_BIT = 2;
  localparam int CTRL_WEXT_BIT = 3;
  localparam int CTRL_OP_LSB   = 4;
  localparam int CTRL_ILEN_LSB = 6;
  localparam int CTRL_IOW_BIT  = 9;
  localparam int CTRL_IO_BIT   = 10;
  localparam int CTRL_BITS     = 11;
  localparam int CMD_GO_BIT    = 0;

  // bit operation and BCD field positions
  localparam int BITOP_NUM_LSB = 8;
  localparam int BITOP_OP_LSB  = 12;
  localparam int BITOP_BITS    = 14;
  localparam int BITOP_TST_BIT = 16;
  localparam int BCD_OK_BIT    = 8;

  // reset values and the full block length
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [23:0] DISP_RST = 24'h00_0000;
  localparam logic [16:0] BLK_MAX  = 17'h1_0000;

  // byte enables, lane i holds the byte for address base+i
  localparam logic [3:0] BE_BYTE = 4'h1;
  localparam logic [3:0] BE_WORD = 4'h3;
  localparam logic [3:0] BE_LONG = 4'hF;

  typedef enum logic [1:0] {
    RAG_OP_JUMP  = 2'b00,
    RAG_OP_STACK = 2'b01,
    RAG_OP_INDEX = 2'b10
  } rag_op_t;

  typedef enum logic [1:0] {
    RAG_DSZ_8  = 2'b00,
    RAG_DSZ_16 = 2'b01,
    RAG_DSZ_24 = 2'b10
  } rag_dsz_t;

  typedef enum logic [1:0] {
    RAG_BIT_TEST = 2'b00,
    RAG_BIT_SET  = 2'b01,
    RAG_BIT_CLR  = 2'b10
  } rag_bitop_t;

  typedef enum logic [1:0] {
    RAG_ST_IDLE = 2'b00,
    RAG_ST_CALC = 2'b01
  } rag_state_t;

  // word extension outranks byte extension
  function automatic rag_dsz_t rag_disp_size(input logic byteExt, input logic wordExt);
    if (wordExt) begin
      return RAG_DSZ_24;
    end
    if (byteExt) begin
      return RAG_DSZ_16;
    end
    return RAG_DSZ_8;
  endfunction : rag_disp_size

  // sign-extend an 8, 16 or 24 bit displacement to 32 bits
  function automatic logic [31:0] rag_sext(input logic [23:0] disp, input rag_dsz_t size);
    case (size)
      RAG_DSZ_16: return {{16{disp[15]}}, disp[15:0]};
      RAG_DSZ_24: return {{8{disp[23]}}, disp};
      default:    return {{24{disp[7]}}, disp[7:0]};
    endcase
  endfunction : rag_sext

endpackage : rag_pkg

// file: hdl/rag_calc_if.sv
// Purpose: request and answer between the register block and the adder
// Assumes: one clock, result valid one cycle after start
// Notes:   ctrl side drives the request, unit side the answer
`timescale 1ns/1ps
interface rag_calc_if;
  import rag_pkg::*;
  logic        start;
  logic        wide;
  rag_op_t     opSel;
  rag_dsz_t    dispSize;
  logic [31:0] base;
  logic [2:0]  instLen;
  logic [23:0] disp;
  logic [31:0] result;
  logic        valid;

  modport unit (input start, wide, opSel, dispSize, base, instLen, disp, output result, valid);
  modport ctrl (output start, wide, opSel, dispSize, base, instLen, disp, input result, valid);
endinterface : rag_calc_if

// file: hdl/rag_addr_unit.sv
// Purpose: effective address adder with mode dependent wrap
// Assumes: start is a one-cycle pulse, inputs stable in that cycle
// Notes:   result and valid come from flip-flops
`timescale 1ns/1ps
module rag_addr_unit
  import rag_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // request and answer
  rag_calc_if.unit calc
);

  logic [31:0] result_ff;
  logic [31:0] nxt_result;
  logic        valid_ff;
  logic        nxt_valid;
  logic [31:0] dispExt;
  logic [31:0] baseAdj;
  logic [15:0] lowSum;

  always_comb begin
    dispExt = rag_sext(calc.disp, calc.dispSize);
    baseAdj = calc.base;
    if (calc.opSel == RAG_OP_JUMP) begin
      baseAdj = calc.base + 32'(calc.instLen); // [RL4]
    end
    // native mode keeps only 16 bits of a 24-bit offset
    lowSum     = baseAdj[15:0] + dispExt[15:0]; // [RL3] [RL8]
    nxt_valid  = calc.start;
    nxt_result = result_ff;
    if (calc.start) begin
      if (calc.wide) begin
        nxt_result = baseAdj + dispExt; // [RL2] [RL7] [RL13]
      end else if (calc.opSel == RAG_OP_JUMP) begin
        nxt_result = {16'h0000, lowSum}; // [RL1]
      end else begin
        nxt_result = {baseAdj[31:16], lowSum}; // [RL5] [RL7]
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result_ff <= WORD_RST;
      valid_ff  <= 1'b0;
    end else begin
      result_ff <= nxt_result;
      valid_ff  <= nxt_valid;
    end
  end

  assign calc.result = result_ff;
  assign calc.valid  = valid_ff;

  a_native_jump_top: assert property (@(posedge clk) disable iff (!arst_n) // [RL1]
    calc.start && !calc.wide && calc.opSel == RAG_OP_JUMP |=> valid_ff && result_ff[31:16] == 16'h0000)
    else $error("native jump target has nonzero upper half");

  a_wide_jump_sum: assert property (@(posedge clk) disable iff (!arst_n) // [RL2]
    calc.start && calc.wide && calc.opSel == RAG_OP_JUMP && calc.dispSize == RAG_DSZ_16
    |=> result_ff == $past(calc.base) + 32'($past(calc.instLen)) + {{16{$past(calc.disp[15])}}, $past(calc.disp[15:0])})
    else $error("extended jump target not a 32-bit sum");

  a_native_jump_low: assert property (@(posedge clk) disable iff (!arst_n) // [RL3]
    calc.start && !calc.wide && calc.opSel == RAG_OP_JUMP && calc.dispSize == RAG_DSZ_8
    |=> result_ff[15:0] == 16'($past(calc.base[15:0]) + 16'($past(calc.instLen)) + {{8{$past(calc.disp[7])}}, $past(calc.disp[7:0])}))
    else $error("native jump low half wrong");

  a_jump_next_base: assert property (@(posedge clk) disable iff (!arst_n) // [RL4]
    calc.start && calc.wide && calc.opSel == RAG_OP_JUMP && calc.disp == DISP_RST
    |=> result_ff == $past(calc.base) + 32'($past(calc.instLen)))
    else $error("jump base is not the next instruction address");

  a_stack_keep_top: assert property (@(posedge clk) disable iff (!arst_n) // [RL7]
    calc.start && !calc.wide && calc.opSel == RAG_OP_STACK |=> result_ff[31:16] == $past(calc.base[31:16]))
    else $error("native stack address touched the upper half");

  a_stack_byte_sext: assert property (@(posedge clk) disable iff (!arst_n) // [RL8]
    calc.start && !calc.wide && calc.opSel == RAG_OP_STACK && calc.dispSize == RAG_DSZ_8
    |=> result_ff[15:0] == 16'($past(calc.base[15:0]) + {{8{$past(calc.disp[7])}}, $past(calc.disp[7:0])}))
    else $error("stack offset not sign extended to 16 bits");

  a_stack_wide_off: assert property (@(posedge clk) disable iff (!arst_n) // [RL6]
    calc.start && calc.wide && calc.opSel == RAG_OP_STACK && calc.dispSize == RAG_DSZ_24
    |=> result_ff == $past(calc.base) + {{8{$past(calc.disp[23])}}, $past(calc.disp)})
    else $error("24-bit stack offset wrong");

  a_index_wide_sum: assert property (@(posedge clk) disable iff (!arst_n) // [RL13]
    calc.start && calc.wide && calc.opSel == RAG_OP_INDEX && calc.dispSize == RAG_DSZ_16
    |=> result_ff == $past(calc.base) + {{16{$past(calc.disp[15])}}, $past(calc.disp[15:0])})
    else $error("indexed address wrong");

  c_native_jump: cover property (@(posedge clk) disable iff (!arst_n)
    calc.start && !calc.wide && calc.opSel == RAG_OP_JUMP);
  c_wide_stack: cover property (@(posedge clk) disable iff (!arst_n)
    calc.start && calc.wide && calc.opSel == RAG_OP_STACK && calc.dispSize == RAG_DSZ_24);
  c_index_wrap: cover property (@(posedge clk) disable iff (!arst_n)
    calc.start && !calc.wide && calc.opSel == RAG_OP_INDEX && calc.disp[7]);

endmodule : rag_addr_unit

// file: testbench/rag_mem_model.sv
// Purpose: memory and I/O spaces behind the address generator
// Assumes: one completed computation is one store of the enabled lanes
// Notes:   unwritten bytes read as x so a missed store never matches
`timescale 1ns/1ps
module rag_mem_model (
  // clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // access from the design
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWdata,
  input wire logic [3:0]  memByteEn,
  input wire logic        memIsIo,
  input wire logic        calcDone
);
  logic [7:0] memSpace [logic [31:0]];
  logic [7:0] ioSpace  [logic [31:0]];
  logic       doneSeen_ff;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      doneSeen_ff <= 1'b0;
    end else begin
      doneSeen_ff <= calcDone;
      if (calcDone && !doneSeen_ff) begin
        for (int i = 0; i < 4; i++) begin
          if (memByteEn[i] && memIsIo) begin
            ioSpace[32'(memAddr + i)] = memWdata[8*i +: 8];
          end else if (memByteEn[i]) begin
            memSpace[32'(memAddr + i)] = memWdata[8*i +: 8];
          end
        end
      end
    end
  end

  function automatic logic [7:0] peek(input logic io, input logic [31:0] a);
    if (io) begin
      return ioSpace.exists(a) ? ioSpace[a] : 8'hxx;
    end
    return memSpace.exists(a) ? memSpace[a] : 8'hxx;
  endfunction : peek
endmodule : rag_mem_model

// file: testbench/rag_top_bench.sv
// Purpose: self-checking bench of the relative address generator
// Assumes: apb slave answers in its own time, one 40 MHz clock
// Notes:   reads and completions are queued and judged by monitors
`timescale 1ns/1ps
module rag_top_bench;
  import rag_pkg::*;
  typedef struct {logic [31:0] val; logic [31:0] mask; logic err;} rag_rd_t;
  typedef struct {logic [31:0] addr; logic [3:0] be; logic io;} rag_exp_t;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, memIsIo, calcDone, doneSeen;
  logic [7:0]  paddr, bv, cv;
  logic [31:0] pwdata, prdata, memAddr, memWdata, b;
  logic [23:0] d;
  logic [3:0]  memByteEn;
  logic [2:0]  bn;
  rag_rd_t     rdQ[$];
  rag_exp_t    calcQ[$];
  int          numErrors, cmpCount;

  rag_top DUT (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .memAddr(memAddr), .memWdata(memWdata), .memByteEn(memByteEn), .memIsIo(memIsIo), .calcDone(calcDone));
  rag_mem_model mem (.clk(clk), .arst_n(arst_n), .memAddr(memAddr), .memWdata(memWdata),
    .memByteEn(memByteEn), .memIsIo(memIsIo), .calcDone(calcDone));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("errors %0d comparisons %0d", numErrors, cmpCount);
    if (numErrors == 0 && cmpCount > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= dat;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      numErrors++;
      stop_test();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m, input logic e);
    rdQ.push_back('{v, m, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic calc(input logic [31:0] ctrl, input logic [31:0] base, input logic [23:0] dp,
                      input logic [31:0] addr, input logic [3:0] be);
    int n;
    apb(1'b1, REG_CTRL, ctrl);
    apb(1'b1, ctrl[5] ? REG_INDEX : (ctrl[4] ? REG_SP : REG_PC), base);
    apb(1'b1, REG_DISP, {8'h00, dp});
    calcQ.push_back('{addr, be, ctrl[10]});
    apb(1'b1, REG_CMD, 32'h0000_0001);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (calcDone !== 1'b1 && n < 20);
    if (calcDone !== 1'b1) begin
      numErrors++;
      stop_test();
    end
    rd(REG_RESULT, addr, 32'hFFFF_FFFF, 1'b0);
    rd(REG_STATUS, {24'h0000_00, be, 4'h1}, 32'h0000_00F3, 1'b0);
    if (ctrl[5:4] == 2'b00) begin
      rd(REG_PC, addr, 32'hFFFF_FFFF, 1'b0);
    end
  endtask : calc

  always @(posedge clk) begin
    rag_rd_t  e;
    rag_exp_t c;
    doneSeen <= calcDone;
    if (psel && penable && pready === 1'b1 && !pwrite && rdQ.size() > 0) begin
      e = rdQ.pop_front();
      check("prdata", prdata & e.mask, e.val);
      check("pslverr", {31'h0, pslverr}, {31'h0, e.err});
    end
    if (calcDone === 1'b1 && doneSeen === 1'b0 && calcQ.size() > 0) begin
      c = calcQ.pop_front();
      check("memAddr", memAddr, c.addr);
      check("memByteEn", {28'h0, memByteEn}, {28'h0, c.be});
      check("memIsIo", {31'h0, memIsIo}, {31'h0, c.io});
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    numErrors++;
    stop_test();
  end

  initial begin
    {arst_n, psel, penable, pwrite, doneSeen} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    numErrors = 0;
    cmpCount = 0;
    void'($urandom(41));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd(8'(4*i), WORD_RST, 32'hFFFF_FFFF, 1'b0);
    end
    rd(8'h30, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
    apb(1'b1, REG_RESULT, 32'hFFFF_FFFF);
    rd(REG_RESULT, 32'h0000_0000, 32'hFFFF_FFFF, 1'b0);
    apb(1'b1, REG_DATA, 32'hEFCD_AB89);
    calc(32'h0000_0080, 32'h0000_1000, 24'h00_00FE, 32'h0000_1000, 4'h0);
    calc(32'h0000_0080, 32'h1234_FFFE, 24'h00_0004, 32'h0000_0004, 4'h0);
    calc(32'h0000_0105, 32'h1959_0807, 24'h00_B000, 32'h1958_B80B, 4'h0);
    calc(32'h0000_0010, 32'h07FF_7F00, 24'h00_00FC, 32'h07FF_7EFC, 4'h3);
    calc(32'h0000_0010, 32'h07FF_0002, 24'h00_00FC, 32'h07FF_FFFE, 4'h3);
    calc(32'h0000_0013, 32'h07FF_7F00, 24'h00_00FC, 32'h07FF_7EFC, 4'hF);
    calc(32'h0000_001B, 32'h07FF_7F00, 24'h01_0000, 32'h0800_7F00, 4'hF);
    for (int i = 0; i < 4; i++) begin
      check("memByte", {24'h0, mem.peek(1'b0, 32'h0800_7F00 + i)}, {24'h0, 8'(32'hEFCD_AB89 >> (8*i))});
    end
    calc(32'h0000_0014, 32'h0000_0010, 24'h00_8000, 32'h0000_8010, 4'h3);
    calc(32'h0000_0029, 32'h0000_0000, 24'h80_0000, 32'hFF80_0000, 4'h3);
    calc(32'h0000_0410, 32'h0000_0100, 24'h00_0001, 32'h0000_0101, 4'h1);
    calc(32'h0000_0610, 32'h0000_0200, 24'h00_0001, 32'h0000_0201, 4'h3);
    check("ioByte", {24'h0, mem.peek(1'b1, 32'h0000_0202)}, 32'h0000_00AB);
    for (int i = 0; i < 4; i++) begin
      b = $urandom;
      d = 24'($urandom);
      calc(32'h0000_0029, b, d, b + {{8{d[23]}}, d}, 4'h3);
      calc(32'h0000_0021, b, d, b + {{24{d[7]}}, d[7:0]}, 4'h3);
      calc(32'h0000_0025, b, d, b + {{16{d[15]}}, d[15:0]}, 4'h3);
      calc(32'h0000_0101, b, 24'h00_0000, b + 32'h0000_0004, 4'h0);
    end
    for (int k = 0; k < 6; k++) begin
      bv = 8'($urandom);
      bn = 3'($urandom);
      apb(1'b1, REG_BITOP, {18'h0, 2'(k % 3), 1'b0, bn, bv});
      if (k % 3 == 0) rd(REG_BITOP, {15'h0, bv[bn], 16'h0}, 32'h0001_0000, 1'b0);
      if (k % 3 == 1) rd(REG_BITOP, {24'h0, bv | (8'h01 << bn)}, 32'h0000_00FF, 1'b0);
      if (k % 3 == 2) rd(REG_BITOP, {24'h0, bv & ~(8'h01 << bn)}, 32'h0000_00FF, 1'b0);
    end
    for (int i = 0; i < 6; i++) begin
      cv = (i < 2) ? (i == 0 ? 8'h99 : 8'h9A) : 8'($urandom);
      apb(1'b1, REG_BCD, {24'h0, cv});
      rd(REG_BCD, {23'h0, (cv[7:4] <= 4'h9 && cv[3:0] <= 4'h9), 8'h00}, 32'h0000_0100, 1'b0);
    end
    apb(1'b1, REG_BLKLEN, 32'h0000_0000);
    rd(REG_BLKLEN, 32'h0001_0000, 32'h0001_FFFF, 1'b0);
    apb(1'b1, REG_BLKLEN, 32'h0000_FFFF);
    rd(REG_BLKLEN, 32'h0000_FFFF, 32'h0001_FFFF, 1'b0);
    repeat (5) @(posedge clk);
    stop_test();
  end
endmodule : rag_top_bench
